// *** bench/parallel_io_ports_asserts.sv ***
// Checker for the parallel port block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports_checks (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_latch_in,
   input wire logic sfr_rd_pin_in,
   input wire logic bit_wr_in,
   input wire logic bit_rd_latch_in,
   input wire logic bit_rd_pin_in,
   input wire logic [2:0][7:0] periph_own_in,
   input wire logic [2:0][7:0] periph_out_in,
   input wire logic [2:0][7:0] periph_oe_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic rd_valid_out,
   input wire logic [2:0][7:0] pin_out_out,
   input wire logic [2:0][7:0] pin_oe_out,
   input wire logic [2:0][7:0] pullup_en_out,
   input wire logic reset_pullup_en_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   wire logic rd = sfr_rd_latch_in | sfr_rd_pin_in | bit_rd_latch_in
      | bit_rd_pin_in;
   property p_rd_answer;
      clk_en_in && rd |=> rd_valid_out;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read without answer");
   property p_rd_idle;
      clk_en_in && !rd |=> !rd_valid_out && sfr_rdata_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data without read");
   property p_wr_rd;
      clk_en_in && sfr_wr_in && sfr_addr_in == 8'h80 && !bit_wr_in ##1
      clk_en_in && sfr_rd_latch_in && !sfr_rd_pin_in && !sfr_wr_in &&
      !bit_wr_in && sfr_addr_in == 8'h80
      |=> sfr_rdata_out == $past(sfr_wdata_in, 2);
   endproperty
   a_wr_rd: assert property (p_wr_rd)
      else $error("latch read differs from write");
   property p_reset;
      $rose(arst_n_in) |-> &pullup_en_out && reset_pullup_en_out &&
         pin_oe_out == '0;
   endproperty
   a_reset: assert property (p_reset)
      else $error("bad pin state after reset");
   property p_own;
      clk_en_in |=> ((pin_out_out ^ $past(periph_out_in)) &
         $past(periph_own_in)) == '0;
   endproperty
   a_own: assert property (p_own)
      else $error("owned pin not given to peripheral");
   property p_own_oe;
      clk_en_in |=> ((pin_oe_out ^ $past(periph_oe_in)) &
         $past(periph_own_in)) == '0;
   endproperty
   a_own_oe: assert property (p_own_oe)
      else $error("owned pin enable not from peripheral");
   property p_p2_drive;
      clk_en_in |=> (pin_out_out[2] & ~$past(periph_own_in[2])) == 8'h00;
   endproperty
   a_p2_drive: assert property (p_p2_drive)
      else $error("port two drives high");
   property p_pu0;
      clk_en_in && sfr_wr_in && sfr_addr_in == 8'hb2 ##1 clk_en_in &&
      !sfr_wr_in |=> pullup_en_out[0] == ~$past(sfr_wdata_in, 2);
   endproperty
   a_pu0: assert property (p_pu0)
      else $error("port zero pull-ups wrong");
   property p_pu1;
      clk_en_in && sfr_wr_in && sfr_addr_in == 8'hb3 ##1 clk_en_in &&
      !sfr_wr_in |=> pullup_en_out[1] == ~$past(sfr_wdata_in, 2);
   endproperty
   a_pu1: assert property (p_pu1)
      else $error("port one pull-ups wrong");
   property p_pu2;
      clk_en_in && sfr_wr_in && sfr_addr_in == 8'hb4 ##1 clk_en_in &&
      !sfr_wr_in |=> pullup_en_out[2] ==
      {5'h1f, ~$past(sfr_wdata_in[2:0], 2)} &&
      reset_pullup_en_out == !$past(sfr_wdata_in[5], 2);
   endproperty
   a_pu2: assert property (p_pu2)
      else $error("port two pull-ups wrong");
endmodule : parallel_io_ports_checks
bind parallel_io_ports parallel_io_ports_checks u_checks (.clk_sys_in,
   .arst_n_in, .clk_en_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in,
   .sfr_rd_latch_in, .sfr_rd_pin_in, .bit_wr_in, .bit_rd_latch_in,
   .bit_rd_pin_in, .periph_own_in, .periph_out_in, .periph_oe_in,
   .sfr_rdata_out, .rd_valid_out, .pin_out_out, .pin_oe_out, .pullup_en_out,
   .reset_pullup_en_out);
`default_nettype wire

// *** bench/pin_world.sv ***
// External devices and line resolution on the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_world (
   input wire logic clk_sys_in,
   input wire logic [2:0][7:0] pin_out_in,
   input wire logic [2:0][7:0] pin_oe_in,
   input wire logic [2:0][7:0] pullup_en_in,
   input wire logic [2:0][7:0] ext_en_in,
   input wire logic [2:0][7:0] ext_val_in,
   output logic [2:0][7:0] level_out
);
   logic [2:0][7:0] drift = '0;
   always @(posedge clk_sys_in) begin
      drift <= ~drift;
   end
   // Driver, then outside device, then pull-up, else a floating line
   always_comb begin
      level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_en_in &
         ext_val_in) | (~pin_oe_in & ~ext_en_in & (pullup_en_in | drift));
   end
endmodule : pin_world
`default_nettype wire

// *** bench/test_parallel_io_ports.sv ***
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module test_parallel_io_ports;
   logic clk_sys_in = 0, arst_n_in = 0, clk_en_in = 1;
   logic [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, bit_addr_in = 0, v;
   logic sfr_wr_in = 0, sfr_rd_latch_in = 0, sfr_rd_pin_in = 0;
   logic bit_wdata_in = 0, bit_wr_in = 0, bit_rd_latch_in = 0;
   logic bit_rd_pin_in = 0, bit_rdata_out, rd_valid_out, reset_pullup_en_out;
   logic [2:0][7:0] periph_own_in = 0, periph_out_in = 0, periph_oe_in = 0;
   logic [2:0][7:0] ext_en = 0, ext_val = 0, pin_in, pin_out_out;
   logic [2:0][7:0] pin_oe_out, pullup_en_out;
   logic [7:0] sfr_rdata_out;
   logic [8:0] exp_q[$];
   int num_errors = 0, samples_checked = 0, cycles = 0, hi, other;
   int map[8] = '{3, 5, 7, 2, 9, 12, 13, 14};
   logic [7:0] regs[9] = '{8'h80, 8'h90, 8'ha0, 8'h9f, 8'hb2, 8'hb3, 8'hb4,
      8'haf, 8'h81};
   parallel_io_ports DUT (.clk_sys_in, .arst_n_in, .clk_en_in, .sfr_addr_in,
      .sfr_wdata_in, .sfr_wr_in, .sfr_rd_latch_in, .sfr_rd_pin_in,
      .bit_addr_in, .bit_wdata_in, .bit_wr_in, .bit_rd_latch_in,
      .bit_rd_pin_in, .periph_own_in, .periph_out_in, .periph_oe_in, .pin_in,
      .sfr_rdata_out, .bit_rdata_out, .rd_valid_out, .pin_out_out,
      .pin_oe_out, .pullup_en_out, .reset_pullup_en_out);
   pin_world partner (.clk_sys_in, .pin_out_in(pin_out_out),
      .pin_oe_in(pin_oe_out), .pullup_en_in(pullup_en_out),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_in));
   initial begin
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   task automatic results;
      if (num_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Kinds: 1 write, 2 read latch, 3 read pin, 4..6 the same by bit
   task automatic op(input int k, input logic [7:0] a, input logic [7:0] d,
      input logic [8:0] e);
      @(posedge clk_sys_in);
      sfr_wr_in <= k == 1;
      sfr_rd_latch_in <= k == 2;
      sfr_rd_pin_in <= k == 3;
      bit_wr_in <= k == 4;
      bit_rd_latch_in <= k == 5;
      bit_rd_pin_in <= k == 6;
      sfr_addr_in <= a;
      bit_addr_in <= a;
      sfr_wdata_in <= d;
      bit_wdata_in <= d[0];
      if (k == 2 || k == 3 || k == 5 || k == 6) exp_q.push_back(e);
   endtask : op
   task automatic idle(input int n);
      repeat (n) op(0, '0, '0, '0);
   endtask : idle
   task automatic watch(input int idx);
      hi = 0;
      other = 0;
      repeat (5262) begin
         @(negedge clk_sys_in);
         hi += int'(pin_out_out[idx / 8][idx % 8] === 1'b1);
         other += int'((pin_out_out & ~(24'h1 << idx)) !== '0);
      end
   endtask : watch
   always @(negedge clk_sys_in) begin
      if (rd_valid_out === 1'b1)
         check("read data", {bit_rdata_out, sfr_rdata_out},
            exp_q.size() != 0 ? exp_q.pop_front() : 9'bx);
   end
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 80000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      void'($urandom(32'hf931b687));
      repeat (4) @(posedge clk_sys_in);
      arst_n_in <= 1;
      foreach (regs[i]) op(2, regs[i], '0, i < 3 ? 9'h0ff : '0);
      for (int p = 0; p < 3; p++) begin
         v = 8'($urandom);
         op(1, regs[p], v, '0);
         op(2, regs[p], '0, {1'b0, v});
         idle(8);
         op(3, regs[p], '0, {1'b0, v});
      end
      v = 8'($urandom);
      op(1, 8'h80, 8'hf0, '0);
      op(1, 8'hb2, 8'hff, '0);
      ext_en[0] <= 8'hf0;
      ext_val[0] <= v;
      idle(8);
      op(3, 8'h80, '0, {1'b0, v[7:4], 4'h0});
      op(6, 8'h87, '0, {v[7], 8'h00});
      op(2, 8'hb2, '0, 9'h0ff);
      op(1, 8'hb2, '0, '0);
      ext_en <= '0;
      for (int a = 3; a < 5; a++) begin
         v = 8'($urandom) & (a == 4 ? 8'h27 : 8'hff);
         op(1, regs[a + 2], v, '0);
         idle(2);
         op(2, regs[a + 2], '0, {1'b0, v});
         op(1, regs[a + 2], '0, '0);
      end
      op(1, 8'h90, 8'hff, '0);
      op(4, 8'h93, '0, '0);
      op(4, 8'hb2, 8'h01, '0);
      op(5, 8'h93, '0, '0);
      op(5, 8'h94, '0, 9'h100);
      op(2, 8'h90, '0, 9'h0f7);
      op(5, 8'hb2, '0, '0);
      op(2, 8'hb2, '0, '0);
      repeat (40) begin
         @(posedge clk_sys_in);
         periph_own_in <= 24'($urandom);
         periph_out_in <= 24'($urandom);
         periph_oe_in <= 24'($urandom);
         clk_en_in <= $urandom % 4 != 0;
      end
      @(posedge clk_sys_in);
      {periph_own_in, periph_out_in, periph_oe_in} <= '0;
      clk_en_in <= 1;
      op(1, 8'h80, 8'h00, '0);
      op(1, 8'h90, 8'h00, '0);
      op(1, 8'h9f, 8'hff, '0);
      idle(2);
      watch(0);
      check("carrier while disabled", 16'(other), '0);
      op(1, 8'haf, 8'h10, '0);
      for (int i = 0; i < 8; i++) begin
         op(1, 8'h9f, 8'h01 << i, '0);
         idle(2);
         watch(map[i]);
         check("carrier high time", 16'(hi), 16'd2631);
         check("carrier on other pin", 16'(other), '0);
      end
      check("reads pending", 16'(exp_q.size()), '0);
      results();
   end
endmodule : test_parallel_io_ports
`default_nettype wire

// *** src/carrier_gen.sv ***
// Square-wave carrier made by counting system clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"
module carrier_gen #(
   parameter logic [11:0] HALF_CYCLES = 12'(`CARRIER_HALF_CYCLES)
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   carrier_if.gen car
);

   gpio_pkg::carrier_state_t s;
   gpio_pkg::carrier_state_t next_s;

   assign car.wave = s.wave;

   always_comb begin
      next_s = s;
      if (!car.run) begin
         next_s.count = 12'h000;
         next_s.wave = 1'b0;
      end else if (s.count >= HALF_CYCLES - 12'h001) begin
         next_s.count = 12'h000;
         next_s.wave = ~s.wave;
      end else begin
         next_s.count = s.count + 12'h001;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s <= '0;
      end else if (clk_en_in) begin
         s <= next_s;
      end
   end

endmodule : carrier_gen
`default_nettype wire

// *** src/carrier_if.sv ***
// Link between the port logic and the carrier generator
`timescale 1ns/1ps
`default_nettype none
interface carrier_if;
   logic run;
   logic wave;
   modport gen (input run, output wave);
   modport user (output run, input wave);
endinterface : carrier_if
`default_nettype wire

// *** src/gpio_params.svh ***
// Constants for the parallel port block: offsets, fields, resets, timing
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

`define ADDR_PORT0 8'h80
`define ADDR_PORT1 8'h90
`define ADDR_PORT2 8'hA0
`define ADDR_CARRIER_SEL 8'h9F
`define ADDR_CFG 8'hAF
`define ADDR_P0_PULLUP 8'hB2
`define ADDR_P1_PULLUP 8'hB3
`define ADDR_P2_PULLUP 8'hB4

`define CFG_CARRIER_EN_BIT 4
`define P2_PULLUP_MASK 8'h27
`define P2_RESET_PIN_BIT 5
`define P2_PULLUP_PINS 3'h7

`define LATCH_RESET 8'hFF
`define SEL_RESET 8'h00
`define PULLUP_OFF_RESET 8'h00

`define BIT_ADDR_BYTE_MASK 8'hF8
`define BIT_ADDR_POS_MASK 8'h07

// Select bit i uses port field [2*i+:2] and bit field [3*i+:3]
`define CARRIER_MAP_PORT {2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0}
`define CARRIER_MAP_BIT {3'h6, 3'h5, 3'h4, 3'h1, 3'h2, 3'h7, 3'h5, 3'h3}

`define CLK_FREQ_HZ 200000000
`define CARRIER_FREQ_HZ 38000
`define CARRIER_HALF_CYCLES (`CLK_FREQ_HZ / (2 * `CARRIER_FREQ_HZ))

`endif

// *** src/gpio_pkg.sv ***
// Types shared by the parallel port block
package gpio_pkg;

   typedef logic [2:0][7:0] port_bits_t;

   typedef struct packed {
      port_bits_t latch;
      port_bits_t pullup_off;
      logic [7:0] carrier_sel;
      logic carrier_en;
      port_bits_t sync1;
      port_bits_t sync2;
      port_bits_t sync3;
      port_bits_t level;
      logic [7:0] rdata;
      logic rbit;
      logic rvalid;
      port_bits_t pin_out;
      port_bits_t pin_oe;
      port_bits_t pullup_en;
      logic reset_pullup_en;
   } gpio_state_t;

   typedef struct packed {
      logic [11:0] count;
      logic wave;
   } carrier_state_t;

endpackage : gpio_pkg

// *** src/parallel_io_ports.sv ***
// Three 8-bit ports with latches, pull-up control and carrier output
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"
module parallel_io_ports (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic clk_en_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_latch_in,
   input wire logic sfr_rd_pin_in,
   input wire logic [7:0] bit_addr_in,
   input wire logic bit_wdata_in,
   input wire logic bit_wr_in,
   input wire logic bit_rd_latch_in,
   input wire logic bit_rd_pin_in,
   input wire logic [2:0][7:0] periph_own_in,
   input wire logic [2:0][7:0] periph_out_in,
   input wire logic [2:0][7:0] periph_oe_in,
   input wire logic [2:0][7:0] pin_in,
   output logic [7:0] sfr_rdata_out,
   output logic bit_rdata_out,
   output logic rd_valid_out,
   output logic [2:0][7:0] pin_out_out,
   output logic [2:0][7:0] pin_oe_out,
   output logic [2:0][7:0] pullup_en_out,
   output logic reset_pullup_en_out
);

   gpio_pkg::gpio_state_t s;
   gpio_pkg::gpio_state_t next_s;
   gpio_pkg::port_bits_t carrier_mask;

   // Fixed pin map of the eight carrier select bits
   localparam logic [15:0] MAP_PORT = `CARRIER_MAP_PORT;
   localparam logic [23:0] MAP_BIT = `CARRIER_MAP_BIT;

   carrier_if car_if ();

   carrier_gen u_carrier (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .clk_en_in(clk_en_in),
      .car(car_if.gen)
   );

   assign car_if.run = s.carrier_en;

   assign sfr_rdata_out = s.rdata;
   assign bit_rdata_out = s.rbit;
   assign rd_valid_out = s.rvalid;
   assign pin_out_out = s.pin_out;
   assign pin_oe_out = s.pin_oe;
   assign pullup_en_out = s.pullup_en;
   assign reset_pullup_en_out = s.reset_pullup_en;

   // Port index of a latch register address, 3 when not a latch
   function automatic logic [1:0] latch_port(input logic [7:0] addr);
      logic [1:0] idx;
      idx = 2'h3;
      if (addr == `ADDR_PORT0) begin
         idx = 2'h0;
      end else if (addr == `ADDR_PORT1) begin
         idx = 2'h1;
      end else if (addr == `ADDR_PORT2) begin
         idx = 2'h2;
      end
      return idx;
   endfunction : latch_port

   // Byte read of any mapped register; unmapped reads as zero
   function automatic logic [7:0] read_byte(
      input gpio_pkg::gpio_state_t st,
      input logic [7:0] addr,
      input logic use_pin
   );
      logic [7:0] val;
      logic [1:0] idx;
      val = 8'h00;
      idx = latch_port(addr);
      if (idx != 2'h3) begin
         if (use_pin) begin
            val = st.level[idx];
         end else begin
            val = st.latch[idx];
         end
      end else if (addr == `ADDR_CARRIER_SEL) begin
         val = st.carrier_sel;
      end else if (addr == `ADDR_CFG) begin
         val[`CFG_CARRIER_EN_BIT] = st.carrier_en;
      end else if (addr == `ADDR_P0_PULLUP) begin
         val = st.pullup_off[0];
      end else if (addr == `ADDR_P1_PULLUP) begin
         val = st.pullup_off[1];
      end else if (addr == `ADDR_P2_PULLUP) begin
         val = st.pullup_off[2] & `P2_PULLUP_MASK;
      end
      return val;
   endfunction : read_byte

   // Pins that carry the carrier when enabled and selected
   always_comb begin
      carrier_mask = '0;
      for (int i = 0; i < 8; i++) begin
         if (s.carrier_en && s.carrier_sel[i]) begin
            carrier_mask[MAP_PORT[2 * i +: 2]]
               [MAP_BIT[3 * i +: 3]] = 1'b1;
         end
      end
   end

   always_comb begin
      logic [1:0] byte_idx;
      logic [1:0] bit_idx;
      logic [2:0] bit_pos;
      logic [7:0] bit_byte;
      logic drive_val;
      logic pull_on;
      byte_idx = 2'h3;
      bit_idx = 2'h3;
      bit_pos = 3'h0;
      bit_byte = 8'h00;
      drive_val = 1'b0;
      pull_on = 1'b0;
      next_s = s;

      // Three-stage pin synchroniser; level moves when the last two stages agree
      next_s.sync1 = pin_in;
      next_s.sync2 = s.sync1;
      next_s.sync3 = s.sync2;
      for (int p = 0; p < 3; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (s.sync2[p][b] == s.sync3[p][b]) begin
               next_s.level[p][b] = s.sync3[p][b];
            end
         end
      end

      // Byte writes, any mapped register
      byte_idx = latch_port(sfr_addr_in);
      if (sfr_wr_in) begin
         if (byte_idx != 2'h3) begin
            next_s.latch[byte_idx] = sfr_wdata_in;
         end else if (sfr_addr_in == `ADDR_CARRIER_SEL) begin
            next_s.carrier_sel = sfr_wdata_in;
         end else if (sfr_addr_in == `ADDR_CFG) begin
            next_s.carrier_en = sfr_wdata_in[`CFG_CARRIER_EN_BIT];
         end else if (sfr_addr_in == `ADDR_P0_PULLUP) begin
            next_s.pullup_off[0] = sfr_wdata_in;
         end else if (sfr_addr_in == `ADDR_P1_PULLUP) begin
            next_s.pullup_off[1] = sfr_wdata_in;
         end else if (sfr_addr_in == `ADDR_P2_PULLUP) begin
            next_s.pullup_off[2] = sfr_wdata_in & `P2_PULLUP_MASK;
         end
      end

      // Bit access reaches only the three latches
      bit_byte = bit_addr_in & `BIT_ADDR_BYTE_MASK;
      bit_pos = 3'(bit_addr_in & `BIT_ADDR_POS_MASK);
      bit_idx = latch_port(bit_byte);
      if (bit_wr_in && bit_idx != 2'h3) begin
         next_s.latch[bit_idx][bit_pos] = bit_wdata_in;
      end

      // Registered read answers, one cycle after the strobe
      next_s.rvalid = sfr_rd_latch_in | sfr_rd_pin_in |
                      bit_rd_latch_in | bit_rd_pin_in;
      next_s.rdata = 8'h00;
      if (sfr_rd_latch_in || sfr_rd_pin_in) begin
         next_s.rdata = read_byte(s, sfr_addr_in, sfr_rd_pin_in);
      end
      next_s.rbit = 1'b0;
      if (bit_idx != 2'h3) begin
         if (bit_rd_pin_in) begin
            next_s.rbit = s.level[bit_idx][bit_pos];
         end else if (bit_rd_latch_in) begin
            next_s.rbit = s.latch[bit_idx][bit_pos];
         end
      end

      // Pin drivers
      for (int p = 0; p < 3; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (p == 2 && b >= 3) begin
               pull_on = 1'b1;
            end else begin
               pull_on = ~s.pullup_off[p][b];
            end
            drive_val = s.latch[p][b] ^
                        (carrier_mask[p][b] & car_if.wave);
            next_s.pullup_en[p][b] = pull_on;
            if (periph_own_in[p][b]) begin
               next_s.pin_out[p][b] = periph_out_in[p][b];
               next_s.pin_oe[p][b] = periph_oe_in[p][b];
            end else if (carrier_mask[p][b] && pull_on) begin
               next_s.pin_out[p][b] = drive_val;
               next_s.pin_oe[p][b] = 1'b1;
            end else begin
               // Low is driven, high left to pull-up or line
               next_s.pin_out[p][b] = 1'b0;
               next_s.pin_oe[p][b] = ~drive_val;
            end
         end
      end
      next_s.reset_pullup_en = ~s.pullup_off[2][`P2_RESET_PIN_BIT];
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s <= '0;
         s.latch <= {3{`LATCH_RESET}};
         s.pullup_off <= {3{`PULLUP_OFF_RESET}};
         s.carrier_sel <= `SEL_RESET;
         s.sync1 <= '1;
         s.sync2 <= '1;
         s.sync3 <= '1;
         s.level <= '1;
         s.pullup_en <= '1;
         s.reset_pullup_en <= 1'b1;
      end else if (clk_en_in) begin
         s <= next_s;
      end
   end

endmodule : parallel_io_ports
`default_nettype wire
